/* core/sts_sequencer.sv */
// controller self-test sequencer: memory, chip, bus and serial interface checks
// assumes a register master on sys_clk and handshake units that answer done/pass on sys_clk
//
// Summary of operation
// - power-on group runs each controller test, reports
// - local RAM range skips vectors and stack
// - walking ones 01h to FFh, write then verify
// - then floating zeros FEh down to 00h
// - mismatch reports address, expected and actual
// - shared RAM FIFO area gets same patterns
// - peripheral chip: patterns in two registers
// - interface chip reset, init, interrupt confirmed
// - memory bus identification read and verified
// - serial tests run at power-up, gate online
// - ten serial tests in order, loop until stop
// - register init check of status registers
// - sector and index clocks plus interrupts checked
// - sector out loops to initialise in
// - valid frames loop back, commands match
// - malformed frames give expected inputs
// - DMA copy to bulk top, back, verify
// - format-at-index then data, DMA data verified
// - read command, DMA feeds serial, sync found
// - external control loop: clock loss, init interrupt
// - external data loop: clock, packet, command interrupt
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "sts_map.svh"
module sts_sequencer
   import sts_pkg::*;
#(
   parameter int AW = 16,
   parameter logic [7:0] MBUS_ID = 8'h5A, // arbitrary identification value
   parameter int HS_TIMEOUT_CYC = `STS_HS_TIMEOUT_CYC
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [1:0] mem_sel,
   output logic [AW-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata,
   output logic [3:0] hs_code,
   output logic hs_start,
   input wire logic hs_done,
   input wire logic hs_pass,
   output logic ctl_loop_en,
   output logic dat_loop_en,
   input wire logic diag_clk,
   output logic online_ok,
   output logic busy
);

   // =========================================================
   // elaboration checks
   if (AW < 16)
   begin : g_bad_aw
      $error("sts_sequencer: AW must be at least 16");
   end
   if (HS_TIMEOUT_CYC < 2)
   begin : g_bad_to
      $error("sts_sequencer: HS_TIMEOUT_CYC too small");
   end

   localparam int DCLK_WIN = `STS_DCLK_WINDOW_CYC;
   localparam int TO_W = $clog2(HS_TIMEOUT_CYC + 1);

   // =========================================================
   // step classification
   function automatic logic step_is_mem(input sts_step_t s);
      return (s == STS_LOCAL) || (s == STS_SHARED) || (s == STS_PERIPH) || (s == STS_MBUS);
   endfunction : step_is_mem

   function automatic logic step_is_serial(input sts_step_t s);
      return (s >= STS_REGINIT);
   endfunction : step_is_serial

   // =========================================================
   // state
   sts_phase_t phase_reg;
   sts_step_t step_reg;
   logic ctrl_ext_ctl_reg;
   logic ctrl_ext_dat_reg;
   logic loop_reg;
   logic stop_reg;
   logic por_pending_reg;
   logic por_run_reg;
   logic fail_reg;
   logic ser_fail_reg;
   logic [15:0] done_bits_reg;
   logic [15:0] fail_bits_reg;
   logic [15:0] pass_cnt_reg;
   logic [AW-1:0] err_addr_reg;
   logic [7:0] err_exp_reg;
   logic [7:0] err_act_reg;
   logic [3:0] err_step_reg;
   logic [TO_W-1:0] to_cnt_reg;
   logic [9:0] win_cnt_reg;
   logic [5:0] edge_cnt_reg;
   logic dclk_s1_reg;
   logic dclk_s2_reg;
   logic dclk_s3_reg;
   logic me_start_reg;

   // =========================================================
   // memory engine wiring
   logic me_done;
   logic me_fail;
   logic [AW-1:0] me_err_addr;
   logic [7:0] me_err_exp;
   logic [7:0] me_err_act;

   wire logic [AW-1:0] lo_sel =
      (step_reg == STS_LOCAL) ? AW'(`STS_LOCAL_LO) :
      (step_reg == STS_SHARED) ? AW'(`STS_SHARED_LO) :
      (step_reg == STS_PERIPH) ? AW'(`STS_PERIPH_LO) : AW'(`STS_MBUS_LO);
   wire logic [AW-1:0] hi_sel =
      (step_reg == STS_LOCAL) ? AW'(`STS_LOCAL_HI) :
      (step_reg == STS_SHARED) ? AW'(`STS_SHARED_HI) :
      (step_reg == STS_PERIPH) ? AW'(`STS_PERIPH_HI) : AW'(`STS_MBUS_HI);
   wire logic mbus_step = (step_reg == STS_MBUS);

   sts_mem_walk #(
      .AW(AW)
   ) u_walk (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(me_start_reg),
      .verify_only(mbus_step),
      .expect_byte(MBUS_ID),
      .lo_addr(lo_sel),
      .hi_addr(hi_sel),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_we(mem_we),
      .mem_re(mem_re),
      .mem_rdata(mem_rdata),
      .done(me_done),
      .fail(me_fail),
      .err_addr(me_err_addr),
      .err_exp(me_err_exp),
      .err_act(me_err_act)
   );

   // =========================================================
   // register decode
   wire logic wr_ctrl = reg_wr && (reg_addr == `STS_CTRL_ADDR);
   wire logic wr_stat = reg_wr && (reg_addr == `STS_STATUS_ADDR);
   wire logic start_all = wr_ctrl && reg_wdata[`STS_CTRL_START_ALL];
   wire logic start_ser = wr_ctrl && reg_wdata[`STS_CTRL_START_SER];
   wire logic stop_wr = wr_ctrl && reg_wdata[`STS_CTRL_STOP];
   wire logic fail_clr = wr_stat && reg_wdata[`STS_STAT_FAIL];

   wire logic [31:0] ctrl_view = {26'h0, ctrl_ext_dat_reg, ctrl_ext_ctl_reg, 1'b0, loop_reg, 2'h0};
   wire logic [31:0] stat_view = {24'h0, step_reg, 1'b0, online_ok, fail_reg, busy};
   wire logic [31:0] rd_mux =
      (reg_addr == `STS_CTRL_ADDR) ? ctrl_view :
      (reg_addr == `STS_STATUS_ADDR) ? stat_view :
      (reg_addr == `STS_DONE_ADDR) ? {16'h0, done_bits_reg} :
      (reg_addr == `STS_FAIL_ADDR) ? {16'h0, fail_bits_reg} :
      (reg_addr == `STS_ERR_ADDR_ADDR) ? 32'(err_addr_reg) :
      (reg_addr == `STS_ERR_DATA_ADDR) ? {12'h0, err_step_reg, err_act_reg, err_exp_reg} :
      (reg_addr == `STS_PASSCNT_ADDR) ? {16'h0, pass_cnt_reg} : 32'h0000_0000;

   // =========================================================
   // diagnostic clock sampling; first stage feeds only the second
   wire logic dclk_rise = dclk_s2_reg && ~dclk_s3_reg;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         dclk_s1_reg <= 1'b0;
         dclk_s2_reg <= 1'b0;
         dclk_s3_reg <= 1'b0;
      end
      else
      begin
         dclk_s1_reg <= diag_clk;
         dclk_s2_reg <= dclk_s1_reg;
         dclk_s3_reg <= dclk_s2_reg;
      end
   end

   // =========================================================
   // step completion
   wire logic is_mem = step_is_mem(step_reg);
   wire logic is_dclk = (step_reg == STS_DCLK);
   wire logic ext_skip = ((step_reg == STS_EXTCTL) && ~ctrl_ext_ctl_reg) ||
                         ((step_reg == STS_EXTDAT) && ~ctrl_ext_dat_reg);
   wire logic to_hit = (to_cnt_reg == TO_W'(HS_TIMEOUT_CYC));
   wire logic win_end = (win_cnt_reg == 10'(DCLK_WIN));
   // a missing interrupt or done shows up as a timeout failure
   wire logic step_end = (phase_reg == PH_WAIT) &&
      (is_mem ? me_done : is_dclk ? win_end : (hs_done || to_hit));
   wire logic step_bad =
      is_mem ? me_fail :
      is_dclk ? (edge_cnt_reg < 6'(`STS_DCLK_MIN_EDGES)) :
      ~(hs_done && hs_pass);
   wire logic last_step = (step_reg == STS_EXTDAT);
   // the STS_EXTDAT step, run or skipped, ends a pass of the group
   wire logic group_end = (phase_reg == PH_NEXT) && last_step;
   wire logic rerun = group_end && loop_reg && ~stop_reg && ~por_run_reg;

   // =========================================================
   // sequencer phase and step
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         phase_reg <= PH_IDLE;
         step_reg <= STS_LOCAL;
      end
      else
      begin
         unique case (phase_reg)
            PH_IDLE:
               if (por_pending_reg || start_all)
               begin
                  step_reg <= STS_LOCAL;
                  phase_reg <= PH_LAUNCH;
               end
               else if (start_ser)
               begin
                  step_reg <= STS_REGINIT;
                  phase_reg <= PH_LAUNCH;
               end
            PH_LAUNCH:
               phase_reg <= ext_skip ? PH_NEXT : PH_WAIT;
            PH_WAIT:
               if (step_end)
                  phase_reg <= PH_NEXT;
            PH_NEXT:
               // a stop only lands here, between steps
               if (rerun)
               begin
                  step_reg <= STS_REGINIT;
                  phase_reg <= PH_LAUNCH;
               end
               else if (last_step || stop_reg)
                  phase_reg <= PH_IDLE;
               else
               begin
                  step_reg <= sts_step_t'(step_reg + 4'h1);
                  phase_reg <= PH_LAUNCH;
               end
         endcase
      end
   end

   // =========================================================
   // launch outputs and counters
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         me_start_reg <= 1'b0;
         hs_start <= 1'b0;
         hs_code <= 4'h0;
         mem_sel <= 2'h0;
         to_cnt_reg <= '0;
         win_cnt_reg <= 10'h000;
         edge_cnt_reg <= 6'h00;
      end
      else
      begin
         me_start_reg <= (phase_reg == PH_LAUNCH) && is_mem && ~ext_skip;
         hs_start <= (phase_reg == PH_LAUNCH) && ~is_mem && ~is_dclk && ~ext_skip;
         if (phase_reg == PH_LAUNCH)
         begin
            hs_code <= step_reg;
            mem_sel <= (step_reg == STS_LOCAL) ? TGT_LOCAL :
                       (step_reg == STS_SHARED) ? TGT_SHARED :
                       (step_reg == STS_PERIPH) ? TGT_PERIPH : TGT_MBUS;
         end
         to_cnt_reg <= (phase_reg == PH_WAIT && ~to_hit) ? to_cnt_reg + TO_W'(1) : '0;
         win_cnt_reg <= (phase_reg == PH_WAIT && is_dclk && ~win_end) ? win_cnt_reg + 10'h001 : 10'h000;
         if (phase_reg != PH_WAIT)
            edge_cnt_reg <= 6'h00;
         else if (dclk_rise && edge_cnt_reg != 6'h3F)
            edge_cnt_reg <= edge_cnt_reg + 6'h01;
      end
   end

   // =========================================================
   // loopback enables follow the current serial step
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctl_loop_en <= 1'b0;
         dat_loop_en <= 1'b0;
      end
      else
      begin
         ctl_loop_en <= (phase_reg != PH_IDLE) && (step_reg >= STS_ICTL) && (step_reg <= STS_SMT);
         dat_loop_en <= (phase_reg != PH_IDLE) && (step_reg >= STS_IDVALID) && (step_reg <= STS_SMT);
      end
   end

   // =========================================================
   // control and results
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctrl_ext_ctl_reg <= 1'b0;
         ctrl_ext_dat_reg <= 1'b0;
         loop_reg <= 1'b0;
         stop_reg <= 1'b0;
         por_pending_reg <= 1'b1;
         por_run_reg <= 1'b0;
         fail_reg <= 1'b0;
         ser_fail_reg <= 1'b0;
         online_ok <= 1'b0;
         busy <= 1'b0;
         done_bits_reg <= 16'h0000;
         fail_bits_reg <= 16'h0000;
         pass_cnt_reg <= 16'h0000;
         err_addr_reg <= '0;
         err_exp_reg <= 8'h00;
         err_act_reg <= 8'h00;
         err_step_reg <= 4'h0;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
         busy <= (phase_reg != PH_IDLE);
         if (wr_ctrl)
         begin
            ctrl_ext_ctl_reg <= reg_wdata[`STS_CTRL_EXT_CTL];
            ctrl_ext_dat_reg <= reg_wdata[`STS_CTRL_EXT_DAT];
            loop_reg <= reg_wdata[`STS_CTRL_LOOP];
         end
         if (phase_reg == PH_IDLE)
         begin
            stop_reg <= 1'b0;
            por_pending_reg <= 1'b0;
            if (por_pending_reg || start_all || start_ser)
            begin
               por_run_reg <= por_pending_reg;
               done_bits_reg <= 16'h0000;
               fail_bits_reg <= 16'h0000;
               ser_fail_reg <= 1'b0;
            end
         end
         else if (stop_wr)
            stop_reg <= 1'b1;
         if (rerun)
         begin
            done_bits_reg <= 16'h0000;
            fail_bits_reg <= 16'h0000;
         end
         else if (step_end)
         begin
            done_bits_reg[step_reg] <= 1'b1;
            fail_bits_reg[step_reg] <= step_bad;
         end
         else if (phase_reg == PH_LAUNCH && ext_skip)
            done_bits_reg[step_reg] <= 1'b1;
         if (group_end)
            pass_cnt_reg <= pass_cnt_reg + 16'h0001;
         // a new failure beats a clear in the same cycle
         if (step_end && step_bad)
            fail_reg <= 1'b1;
         else if (fail_clr)
            fail_reg <= 1'b0;
         if (step_end && step_bad)
         begin
            err_step_reg <= step_reg;
            err_addr_reg <= is_mem ? me_err_addr : '0;
            err_exp_reg <= is_mem ? me_err_exp : 8'h00;
            err_act_reg <= is_mem ? me_err_act : 8'h00;
            if (step_is_serial(step_reg))
            begin
               ser_fail_reg <= 1'b1;
               online_ok <= 1'b0;
            end
         end
         // online only after a clean serial group
         if (group_end && ~ser_fail_reg)
            online_ok <= 1'b1;
      end
   end

endmodule : sts_sequencer

/* core/sts_map.svh */
// register map, field positions, test memory ranges and timing counts of the self-test sequencer
// assumes a 200 MHz system clock and a byte-wide test memory port
`ifndef STS_MAP_SVH
`define STS_MAP_SVH

// =========================================================
// register byte addresses
`define STS_CTRL_ADDR       8'h00
`define STS_STATUS_ADDR     8'h04
`define STS_DONE_ADDR       8'h08
`define STS_FAIL_ADDR       8'h0C
`define STS_ERR_ADDR_ADDR   8'h10
`define STS_ERR_DATA_ADDR   8'h14
`define STS_PASSCNT_ADDR    8'h18

// =========================================================
// control register fields (write pulses except the enables)
`define STS_CTRL_START_ALL  0
`define STS_CTRL_START_SER  1
`define STS_CTRL_LOOP       2
`define STS_CTRL_STOP       3
`define STS_CTRL_EXT_CTL    4
`define STS_CTRL_EXT_DAT    5

// status register fields; writing 1 to the fail bit clears it
`define STS_STAT_BUSY       0
`define STS_STAT_FAIL       1
`define STS_STAT_ONLINE     2
`define STS_STAT_STEP_LSB   4

// =========================================================
// test memory ranges, byte addresses on the test port
`define STS_LOCAL_LO        16'h0100
`define STS_LOCAL_HI        16'h0EFF
`define STS_SHARED_LO       16'h0000
`define STS_SHARED_HI       16'h03FF
`define STS_PERIPH_LO       16'h0000
`define STS_PERIPH_HI       16'h0001
`define STS_MBUS_LO         16'h0000
`define STS_MBUS_HI         16'h0003

// =========================================================
// timing
`define STS_CLK_PERIOD_PS   5000
`define STS_HS_TIMEOUT_US   100
`define STS_HS_TIMEOUT_CYC  ((`STS_HS_TIMEOUT_US * 1000000) / `STS_CLK_PERIOD_PS)
`define STS_DCLK_WINDOW_NS  4000
`define STS_DCLK_WINDOW_CYC ((`STS_DCLK_WINDOW_NS * 1000) / `STS_CLK_PERIOD_PS)
`define STS_DCLK_MIN_EDGES  16

`endif

/* core/sts_pkg.sv */
// types shared by the self-test sequencer and its memory pattern engine
// assumes nothing beyond a SystemVerilog compiler
package sts_pkg;

   // test steps in execution order
   typedef enum logic [3:0] {
      STS_LOCAL, STS_SHARED, STS_PERIPH, STS_IFCHIP, STS_PLA, STS_MBUS,
      STS_REGINIT, STS_DCLK, STS_SECTOR, STS_ICTL, STS_IDVALID, STS_IDINVALID,
      STS_DMA, STS_SMT, STS_EXTCTL, STS_EXTDAT
   } sts_step_t;

   // sequencer phase
   typedef enum logic [1:0] {PH_IDLE, PH_LAUNCH, PH_WAIT, PH_NEXT} sts_phase_t;

   // memory engine state
   typedef enum logic [1:0] {ME_IDLE, ME_WRITE, ME_READ, ME_CMP} sts_mstate_t;

   // memory target select
   typedef enum logic [1:0] {TGT_LOCAL, TGT_SHARED, TGT_PERIPH, TGT_MBUS} sts_target_t;

endpackage : sts_pkg

/* core/sts_mem_walk.sv */
// walking-ones / floating-zeros pattern engine for a byte-wide memory port
// assumes read data return one clock after the read strobe
`timescale 1ns/1ps
module sts_mem_walk
   import sts_pkg::*;
#(
   parameter int AW = 16
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic verify_only,
   input wire logic [7:0] expect_byte,
   input wire logic [AW-1:0] lo_addr,
   input wire logic [AW-1:0] hi_addr,
   output logic [AW-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re,
   input wire logic [7:0] mem_rdata,
   output logic done,
   output logic fail,
   output logic [AW-1:0] err_addr,
   output logic [7:0] err_exp,
   output logic [7:0] err_act
);

   // =========================================================
   // pattern table
   function automatic logic [7:0] walk_pattern(input logic [3:0] idx);
      if (idx < 4'h8)
         return 8'hFF >> (3'h7 - idx[2:0]);
      else
         return 8'hFF << ({1'b0, idx[2:0]} + 4'h1);
   endfunction : walk_pattern

   sts_mstate_t state_reg;
   logic [3:0] pat_reg;
   logic vo_reg;
   logic [7:0] exp_reg;

   wire logic [7:0] cur_exp = vo_reg ? exp_reg : walk_pattern(pat_reg);
   wire logic mismatch = (mem_rdata != cur_exp);
   wire logic last_addr = (mem_addr == hi_addr);
   wire logic last_pat = vo_reg || (pat_reg == 4'hF);

   // =========================================================
   // engine
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_reg <= ME_IDLE;
         pat_reg <= 4'h0;
         vo_reg <= 1'b0;
         exp_reg <= 8'h00;
         mem_addr <= '0;
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         err_addr <= '0;
         err_exp <= 8'h00;
         err_act <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         unique case (state_reg)
            ME_IDLE:
               if (start)
               begin
                  fail <= 1'b0;
                  vo_reg <= verify_only;
                  exp_reg <= expect_byte;
                  pat_reg <= 4'h0;
                  mem_addr <= lo_addr;
                  state_reg <= verify_only ? ME_READ : ME_WRITE;
               end
            ME_WRITE:
            begin
               // each location is written, then read back at once
               mem_wdata <= cur_exp;
               mem_we <= 1'b1;
               state_reg <= ME_READ;
            end
            ME_READ:
            begin
               mem_re <= 1'b1;
               state_reg <= ME_CMP;
            end
            ME_CMP:
               if (mem_re)
                  state_reg <= ME_CMP;
               else if (mismatch)
               begin
                  // first mismatch ends the run with its evidence
                  err_addr <= mem_addr;
                  err_exp <= cur_exp;
                  err_act <= mem_rdata;
                  fail <= 1'b1;
                  done <= 1'b1;
                  state_reg <= ME_IDLE;
               end
               else if (last_addr && last_pat)
               begin
                  done <= 1'b1;
                  state_reg <= ME_IDLE;
               end
               else
               begin
                  mem_addr <= last_addr ? lo_addr : mem_addr + AW'(1);
                  pat_reg <= last_addr ? pat_reg + 4'h1 : pat_reg;
                  state_reg <= vo_reg ? ME_READ : ME_WRITE;
               end
         endcase
      end
   end

endmodule : sts_mem_walk

/* bench/sts_sequencer_asserts.sv */
// port checker for the self-test sequencer
// assumes binding onto sts_sequencer, all on sys_clk
`timescale 1ns/1ps
`include "sts_map.svh"
module sts_sequencer_asserts
   import sts_pkg::*;
#(
   parameter int AW = 16
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0] mem_sel,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic [3:0] hs_code,
   input wire logic hs_start,
   input wire logic ctl_loop_en,
   input wire logic dat_loop_en
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // =========================================
   // memory walk, handshake steps and register read data
   sequence s_verify;
      mem_re && $stable(mem_addr) ##1 !mem_we && !mem_re;
   endsequence
   sequence s_held;
      $stable(hs_code)[*3];
   endsequence
   chk_write_then_read: assert property (mem_we |=> s_verify)
      else $error("no read after write");
   chk_pattern_shape: assert property (mem_we |-> ((mem_wdata & 8'(mem_wdata + 8'h01)) == 8'h00)
      || ((~mem_wdata & 8'(~mem_wdata + 8'h01)) == 8'h00))
      else $error("bad pattern");
   chk_local_range: assert property (mem_we && mem_sel == 2'd0 |-> mem_addr inside {[`STS_LOCAL_LO:`STS_LOCAL_HI]})
      else $error("local write out of range");
   chk_shared_range: assert property (mem_we && mem_sel == 2'd1 |-> mem_addr <= `STS_SHARED_HI)
      else $error("shared write out of range");
   chk_periph_regs: assert property (mem_we && mem_sel == 2'd2 |-> mem_addr <= 16'h0001)
      else $error("periph write out of range");
   chk_bus_readonly: assert property (mem_sel == 2'd3 |-> !mem_we)
      else $error("write on identification bus");
   chk_code_held: assert property (hs_start |=> s_held)
      else $error("step code moved");
   chk_ctl_loop: assert property (hs_start && hs_code inside {[STS_ICTL:STS_SMT]} |=> ctl_loop_en)
      else $error("control loop not enabled");
   chk_dat_loop: assert property (hs_start && hs_code inside {[STS_IDVALID:STS_SMT]} |=> dat_loop_en)
      else $error("data loop not enabled");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule : sts_sequencer_asserts

/* bench/sts_host_model.sv */
// far side model: byte memories with one cycle read latency and a handshake test unit
// assumes the sequencer's memory and handshake ports on sys_clk
`timescale 1ns/1ps
module sts_host_model
#(
   parameter logic [7:0] ID = 8'h3C // arbitrary
)(
   input wire logic sys_clk,
   input wire logic [1:0] mem_sel,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic mem_re,
   output logic [7:0] mem_rdata,
   input wire logic [3:0] hs_code,
   input wire logic hs_start,
   output logic hs_done,
   output logic hs_pass,
   input wire logic corrupt_local,
   input wire logic [4:0] fail_code
);
   logic [7:0] m [0:3][0:4095];
   logic [2:0] wait_reg;
   logic [3:0] code_reg;
   logic [3:0] codes [$];
   int n_done;
   // =========================================
   // memories and step unit
   initial
   begin
      for (int i = 0; i < 4096; i++) m[3][i] = ID;
      mem_rdata = 8'h00;
      hs_done = 1'b0;
      hs_pass = 1'b0;
      wait_reg = 3'd0;
      n_done = 0;
   end
   always @(posedge sys_clk)
   begin
      if (mem_we) m[mem_sel][mem_addr[11:0]] <= mem_wdata;
      // idle lines toggle to expose late samples
      mem_rdata <= mem_re ? m[mem_sel][mem_addr[11:0]] ^ (corrupt_local && mem_sel == 2'd0 ? 8'h04 : 8'h00) : ~mem_rdata;
      hs_done <= wait_reg == 3'd1;
      hs_pass <= wait_reg == 3'd1 ? {1'b0, code_reg} != fail_code : ~hs_pass;
      if (wait_reg == 3'd1) n_done <= n_done + 1;
      if (hs_start)
      begin
         wait_reg <= 3'd4;
         code_reg <= hs_code;
         codes.push_back(hs_code);
      end
      else if (wait_reg != 3'd0) wait_reg <= wait_reg - 3'd1;
   end
endmodule : sts_host_model

/* bench/sts_sequencer_test.sv */
// bench: power-up run, cleared flag, failing serial step, looped group with stop
// assumes sts_host_model on the far side
`timescale 1ns/1ps
`include "sts_map.svh"
module sts_sequencer_test
   import sts_pkg::*;
;
   localparam logic [7:0] ID = 8'h3C; // arbitrary
   logic sys_clk, rst, reg_wr, reg_rd, mem_we, mem_re, hs_start, hs_done, hs_pass;
   logic ctl_loop_en, dat_loop_en, diag_clk, online_ok, busy, corrupt_local;
   logic [7:0] reg_addr, mem_wdata, mem_rdata;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0] mem_sel;
   logic [15:0] mem_addr;
   logic [3:0] hs_code;
   logic [4:0] fail_code;
   int n_errors, num_checks, cyc;
   sts_sequencer #(.AW(16), .MBUS_ID(ID), .HS_TIMEOUT_CYC(50)) dut (.*);
   sts_host_model #(.ID(ID)) u_host (.*);
   // =========================================
   // bus and compare tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask : rd
   task automatic wait_idle;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(posedge sys_clk);
   endtask : wait_idle
   function automatic logic [31:0] pack(input int s, input int n);
      logic [31:0] v;
      v = 32'h0;
      for (int i = s; i < s + n; i++) v = {v[27:0], u_host.codes[i]};
      return v;
   endfunction : pack
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   // =========================================
   // scenarios
   task automatic t_powerup;
      logic [31:0] v;
      wait_idle();
      rd(`STS_DONE_ADDR, v);
      chk("done", 32'h0000FFFF, v);
      rd(`STS_FAIL_ADDR, v);
      chk("fail", 32'h00000001, v);
      rd(`STS_ERR_ADDR_ADDR, v);
      chk("err addr", 32'h00000100, v);
      rd(`STS_ERR_DATA_ADDR, v);
      chk("err data", 32'h00000501, v);
      chk("online", 32'h1, {31'h0, online_ok});
      chk("order", 32'h0689ABCD, pack(u_host.codes.size() - 7, 7));
      $display("powerup test done");
   endtask : t_powerup
   task automatic t_clear;
      logic [31:0] v;
      wr(`STS_STATUS_ADDR, 32'h2);
      rd(`STS_STATUS_ADDR, v);
      chk("fail flag", 32'h0, {31'h0, v[1]});
      rd(8'h1C, v);
      chk("unmapped", 32'h0, v);
      $display("clear test done");
   endtask : t_clear
   task automatic t_serial_fail;
      logic [31:0] v;
      fail_code <= 5'd8;
      wr(`STS_CTRL_ADDR, 32'h2);
      wait_idle();
      rd(`STS_FAIL_ADDR, v);
      chk("sector fail", 32'h1, {31'h0, v[8]});
      chk("online", 32'h0, {31'h0, online_ok});
      rd(`STS_STATUS_ADDR, v);
      chk("sticky", 32'h1, {31'h0, v[1]});
      fail_code <= 5'd16;
      $display("serial fail test done");
   endtask : t_serial_fail
   task automatic t_loop_stop;
      logic [31:0] v;
      int n0;
      u_host.codes.delete();
      n0 = u_host.n_done;
      wr(`STS_CTRL_ADDR, 32'h36);
      rd(`STS_CTRL_ADDR, v);
      chk("ctrl", 32'h34, v);
      for (int i = 0; i < 5000 && u_host.codes.size() < 18; i++) @(posedge sys_clk);
      wr(`STS_CTRL_ADDR, 32'h8);
      wait_idle();
      chk("group", 32'h689ABCDE, pack(0, 8));
      chk("ext", 32'h89ABCDEF, pack(1, 8));
      chk("repeat", 32'h689ABCDE, pack(9, 8));
      chk("whole steps", u_host.codes.size(), u_host.n_done - n0);
      chk("busy", 32'h0, {31'h0, busy});
      $display("loop stop test done");
   endtask : t_loop_stop
   always #2.5 sys_clk = ~sys_clk;
   initial
   begin
      #1.3;
      forever #80 diag_clk = ~diag_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         n_errors++;
         summarize();
      end
   end
   initial
   begin
      {sys_clk, diag_clk, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {rst, corrupt_local, fail_code} = {2'b11, 5'd16};
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      t_powerup();
      t_clear();
      t_serial_fail();
      t_loop_stop();
      summarize();
   end
endmodule : sts_sequencer_test
bind sts_sequencer sts_sequencer_asserts #(.AW(AW)) u_chk (.*);
